/* File: hdl/indwd_defs.svh */
// Constants for the independent watchdog: offsets, command words, resets, fields.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef INDWD_DEFS_SVH
`define INDWD_DEFS_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define INDWD_OFF_CMD 4'h0
`define INDWD_OFF_DIV 4'h4
`define INDWD_OFF_RST 4'h8
`define INDWD_OFF_STS 4'hC
// ****************************************
// Command words and field values
// ****************************************
`define INDWD_CMD_START 16'hCCCC
`define INDWD_CMD_RELOAD 16'hAAAA
`define INDWD_CMD_UNLOCK 16'h5555
`define INDWD_CNT_FULL 12'hFFF
`define INDWD_RESTART_RST 12'hFFF
`define INDWD_DIV_RST 3'h0
`define INDWD_DIV_MAX_CODE 3'h5
`define INDWD_DIV_BASE 9'h004
`define INDWD_DIV_TOP 9'h100
`define INDWD_STS_DIV_BIT 0
`define INDWD_STS_RST_BIT 1
`define INDWD_RESP_OKAY 2'h0
`define INDWD_RESP_SLVERR 2'h2
// Documented timeout span, in milliseconds, set by the low-speed tick rate
`define INDWD_TIMEOUT_MIN_MS 0.1
`define INDWD_TIMEOUT_MAX_MS 26214.4
`endif

/* File: hdl/indwd_pkg.sv */
// Types shared by the independent watchdog modules.
// Assumes indwd_defs.svh is on the include path.
`include "indwd_defs.svh"
package indwd_pkg;
    // ****************************************
    // Types
    // ****************************************
    typedef logic [11:0] indwd_count_t;
    typedef logic [2:0] indwd_div_t;
    typedef enum logic [1:0] {
        INDWD_ST_IDLE = 2'b00,
        INDWD_ST_RUN = 2'b01,
        INDWD_ST_FIRED = 2'b10
    } indwd_state_t;

    // Division ratio of the low-speed tick for a selector code
    function automatic logic [8:0] indwd_div_limit(input indwd_div_t sel);
        logic [8:0] lim;
        lim = `INDWD_DIV_TOP;
        if (sel <= `INDWD_DIV_MAX_CODE) begin
            lim = `INDWD_DIV_BASE << sel;
        end
        return lim;
    endfunction
endpackage

/* File: hdl/indwd_ctl_if.sv */
// Control bundle between the watchdog register side, prescaler and counter.
// Assumes one clock and a synchronous active-high reset for all three.
`timescale 1ns/10ps
interface indwd_ctl_if (
    input wire logic clk,
    input wire logic rst
);
    import indwd_pkg::*;
    logic clk_en;
    logic lsi_tick;
    logic freeze;
    logic permit;
    logic start_req;
    logic reload_req;
    indwd_div_t div_sel;
    indwd_count_t restart_val;
    logic presc_clear;
    logic div_tick;
    indwd_count_t count;
    indwd_state_t state;
    logic sys_reset;
    modport top (input clk, rst, presc_clear, div_tick, count, state, sys_reset,
        output clk_en, lsi_tick, freeze, permit, start_req, reload_req, div_sel,
        restart_val);
    modport presc (input clk, rst, clk_en, lsi_tick, freeze, div_sel, presc_clear,
        output div_tick);
    modport cnt (input clk, rst, clk_en, permit, start_req, reload_req,
        restart_val, div_tick, output presc_clear, count, state, sys_reset);
endinterface

/* File: hdl/indwd_prescaler.sv */
// Divider of the low-speed tick into counter decrement ticks.
// Assumes ticks arrive as one-cycle pulses synchronous to the core clock.
`timescale 1ns/10ps
`include "indwd_defs.svh"
module indwd_prescaler
    import indwd_pkg::*;
(
    indwd_ctl_if.presc ctl
);
    logic [8:0] presc_cnt_reg;
    logic [8:0] limit;
    logic run;

    // Halted debug with freeze stops the prescaler, and so the counter
    assign run = ctl.lsi_tick && !ctl.freeze;
    assign limit = indwd_div_limit(ctl.div_sel);
    // Greater-or-equal guards against a ratio shrinking under a high count
    assign ctl.div_tick = run && (presc_cnt_reg >= (limit - 9'h001));

    // Prescaler count, restarted on every counter load
    always_ff @(posedge ctl.clk) begin
        if (ctl.rst) begin
            presc_cnt_reg <= 9'h000;
        end else if (ctl.clk_en) begin
            if (ctl.presc_clear) begin
                presc_cnt_reg <= 9'h000;
            end else if (ctl.div_tick) begin
                presc_cnt_reg <= 9'h000;
            end else if (run) begin
                presc_cnt_reg <= presc_cnt_reg + 9'h001;
            end
        end
    end

    a_freeze_no_tick: assert property (@(posedge ctl.clk) disable iff (ctl.rst)
        ctl.freeze |-> !ctl.div_tick)
        else $error("prescaler ticked while frozen");
    // A tick must restart the phase, so the next tick is a full ratio away
    a_tick_spacing: assert property (@(posedge ctl.clk) disable iff (ctl.rst)
        (ctl.clk_en && ctl.div_tick && ctl.div_sel == 3'h0) |=>
        (!ctl.div_tick && presc_cnt_reg == 9'h000))
        else $error("divide by four ticked too early");
endmodule

/* File: hdl/indwd_counter.sv */
// Twelve-bit watchdog down-counter with start, reload and reset firing.
// Assumes load requests are one-cycle pulses or held levels from the register side.
`timescale 1ns/10ps
`include "indwd_defs.svh"
module indwd_counter
    import indwd_pkg::*;
(
    indwd_ctl_if.cnt ctl
);
    indwd_state_t state_reg;
    indwd_count_t count_reg;
    logic sys_reset_reg;

    // Any load of the counter restarts the prescaler phase
    assign ctl.presc_clear = (state_reg == INDWD_ST_IDLE && ctl.start_req) ||
        (state_reg == INDWD_ST_RUN && ctl.reload_req);
    assign ctl.count = count_reg;
    assign ctl.state = state_reg;
    assign ctl.sys_reset = sys_reset_reg;

    // Countdown state; the fired reset holds until the system reset arrives
    always_ff @(posedge ctl.clk) begin
        if (ctl.rst) begin
            state_reg <= INDWD_ST_IDLE;
            count_reg <= `INDWD_CNT_FULL;
            sys_reset_reg <= 1'b0;
        end else if (ctl.clk_en) begin
            case (state_reg)
                INDWD_ST_IDLE: begin
                    if (ctl.start_req) begin
                        count_reg <= `INDWD_CNT_FULL;
                        state_reg <= INDWD_ST_RUN;
                    end
                end
                INDWD_ST_RUN: begin
                    if (ctl.reload_req) begin
                        count_reg <= ctl.restart_val;
                    end else if (count_reg == 12'h000 && ctl.permit) begin
                        state_reg <= INDWD_ST_FIRED;
                        sys_reset_reg <= 1'b1;
                    end else if (ctl.div_tick) begin
                        // Without permission the count simply wraps on
                        count_reg <= count_reg - 12'h001;
                    end
                end
                INDWD_ST_FIRED: begin
                    sys_reset_reg <= 1'b1;
                end
                default: begin
                    state_reg <= INDWD_ST_IDLE;
                end
            endcase
        end
    end

    a_start_full: assert property (@(posedge ctl.clk) disable iff (ctl.rst)
        (ctl.clk_en && state_reg == INDWD_ST_IDLE && ctl.start_req) |=>
        (count_reg == `INDWD_CNT_FULL && state_reg == INDWD_ST_RUN))
        else $error("start did not load full scale");
    a_reload_value: assert property (@(posedge ctl.clk) disable iff (ctl.rst)
        (ctl.clk_en && state_reg == INDWD_ST_RUN && ctl.reload_req) |=>
        count_reg == $past(ctl.restart_val))
        else $error("reload did not load restart value");
    a_zero_fires: assert property (@(posedge ctl.clk) disable iff (ctl.rst)
        (ctl.clk_en && state_reg == INDWD_ST_RUN && count_reg == 12'h000 &&
        ctl.permit && !ctl.reload_req) |=> sys_reset_reg ##1 sys_reset_reg)
        else $error("zero count did not fire reset");
    a_no_permit: assert property (@(posedge ctl.clk) disable iff (ctl.rst)
        (state_reg == INDWD_ST_RUN && !ctl.permit) |=> !sys_reset_reg)
        else $error("reset fired without permission");
endmodule

/* File: hdl/indwd_top.sv */
// Independent watchdog top: AXI4-Lite register slave, write protection, update
// crossing toward the low-speed tick, and the prescaler and counter instances.
// Assumes low-speed ticks and option pins are synchronous to CORE_CLK_IN.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`include "indwd_defs.svh"
module indwd_top
    import indwd_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // Clock, reset and clock enable
    input wire logic CORE_CLK_IN,
    input wire logic RESET_IN,
    input wire logic CLK_EN_IN,
    // Low-speed oscillator tick and system controls
    input wire logic LSI_TICK_IN,
    input wire logic HW_START_OPTION_IN,
    input wire logic RESET_PERMIT_IN,
    input wire logic DEBUG_HALT_IN,
    input wire logic DEBUG_HALT_FREEZE_IN,
    // Watchdog reset
    output logic SYS_RESET_OUT,
    // AXI4-Lite write channels
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    // AXI4-Lite read channels
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN
);
    // ****************************************
    // Address decode
    // ****************************************
    // Returns the low nibble when the upper address bits are zero, else an
    // odd code that no register matches
    function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] addr);
        logic [3:0] sel;
        sel = 4'h1;
        if ((addr >> 4) == '0) begin
            sel = addr[3:0];
        end
        return sel;
    endfunction

    function automatic logic is_mapped(input logic [3:0] sel);
        return sel == `INDWD_OFF_CMD || sel == `INDWD_OFF_DIV ||
            sel == `INDWD_OFF_RST || sel == `INDWD_OFF_STS;
    endfunction

    indwd_ctl_if ctl (.clk(CORE_CLK_IN), .rst(RESET_IN));

    logic aw_held_reg;
    logic [3:0] aw_sel_reg;
    logic w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic unlock_reg;
    indwd_div_t div_reg;
    indwd_div_t div_active_reg;
    logic div_pend_reg;
    indwd_count_t restart_reg;
    indwd_count_t restart_active_reg;
    logic restart_pend_reg;
    logic wr_fire;
    logic cmd_wr;
    logic [15:0] cmd_word;
    logic start_cmd;
    logic reload_cmd;
    logic div_wr;
    logic restart_wr;
    logic [3:0] ar_sel;
    logic [31:0] rd_word;

    // ****************************************
    // AXI4-Lite write path
    // ****************************************
    // One write at a time: address and data are held until the response is raised, and no new one is taken until it leaves
    assign S_AXI_AWREADY_OUT = !aw_held_reg && !bvalid_reg;
    assign S_AXI_WREADY_OUT = !w_held_reg && !bvalid_reg;
    assign S_AXI_BVALID_OUT = bvalid_reg;
    assign S_AXI_BRESP_OUT = bresp_reg;
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

    // Write address and data capture, in either order
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            aw_held_reg <= 1'b0;
            aw_sel_reg <= 4'h0;
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (CLK_EN_IN) begin
            if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
                aw_held_reg <= 1'b1;
                aw_sel_reg <= reg_sel(S_AXI_AWADDR_IN);
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
                w_held_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA_IN;
                w_strb_reg <= S_AXI_WSTRB_IN;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Write response; unmapped offsets answer with a slave error
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `INDWD_RESP_OKAY;
        end else if (CLK_EN_IN) begin
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= is_mapped(aw_sel_reg) ? `INDWD_RESP_OKAY : `INDWD_RESP_SLVERR;
            end else if (S_AXI_BREADY_IN) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // Command decode and write protection
    // ****************************************
    // A command counts only when both low byte lanes carry it
    assign cmd_wr = wr_fire && aw_sel_reg == `INDWD_OFF_CMD && w_strb_reg[1:0] == 2'h3;
    assign cmd_word = w_data_reg[15:0];
    assign start_cmd = cmd_wr && cmd_word == `INDWD_CMD_START;
    assign reload_cmd = cmd_wr && cmd_word == `INDWD_CMD_RELOAD;
    // Field writes need the unlock and an idle crossing for that field
    assign div_wr = wr_fire && aw_sel_reg == `INDWD_OFF_DIV && w_strb_reg[0] &&
        unlock_reg && !div_pend_reg;
    assign restart_wr = wr_fire && aw_sel_reg == `INDWD_OFF_RST &&
        w_strb_reg[1:0] == 2'h3 && unlock_reg && !restart_pend_reg;

    // Any command other than unlock, reload included, locks the fields again
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            unlock_reg <= 1'b0;
        end else if (CLK_EN_IN && cmd_wr) begin
            unlock_reg <= (cmd_word == `INDWD_CMD_UNLOCK);
        end
    end

    // ****************************************
    // Field registers and update crossing
    // ****************************************
    // A write raises pending; the next low-speed tick takes the value over
    // and drops it. Set wins, though the guard on the write keeps them apart.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            div_reg <= `INDWD_DIV_RST;
            div_active_reg <= `INDWD_DIV_RST;
            div_pend_reg <= 1'b0;
        end else if (CLK_EN_IN) begin
            if (div_wr) begin
                div_reg <= w_data_reg[2:0];
                div_pend_reg <= 1'b1;
            end else if (LSI_TICK_IN && div_pend_reg) begin
                div_active_reg <= div_reg;
                div_pend_reg <= 1'b0;
            end
        end
    end

    // Restart value follows the same crossing
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            restart_reg <= `INDWD_RESTART_RST;
            restart_active_reg <= `INDWD_RESTART_RST;
            restart_pend_reg <= 1'b0;
        end else if (CLK_EN_IN) begin
            if (restart_wr) begin
                restart_reg <= w_data_reg[11:0];
                restart_pend_reg <= 1'b1;
            end else if (LSI_TICK_IN && restart_pend_reg) begin
                restart_active_reg <= restart_reg;
                restart_pend_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // AXI4-Lite read path
    // ****************************************
    assign ar_sel = reg_sel(S_AXI_ARADDR_IN);
    assign S_AXI_ARREADY_OUT = !rvalid_reg;
    assign S_AXI_RVALID_OUT = rvalid_reg;
    assign S_AXI_RDATA_OUT = rdata_reg;
    assign S_AXI_RRESP_OUT = rresp_reg;

    // Read mux; the command register is write-only and reads as zero.
    // Field readback is the bus-side copy, which may lead the tick side.
    always_comb begin
        rd_word = 32'h0000_0000;
        case (ar_sel)
            `INDWD_OFF_DIV: rd_word[2:0] = div_reg;
            `INDWD_OFF_RST: rd_word[11:0] = restart_reg;
            `INDWD_OFF_STS: begin
                rd_word[`INDWD_STS_DIV_BIT] = div_pend_reg;
                rd_word[`INDWD_STS_RST_BIT] = restart_pend_reg;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Read response register
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `INDWD_RESP_OKAY;
        end else if (CLK_EN_IN) begin
            if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_word;
                rresp_reg <= is_mapped(ar_sel) ? `INDWD_RESP_OKAY : `INDWD_RESP_SLVERR;
            end else if (S_AXI_RREADY_IN) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // Counting core
    // ****************************************
    // Hardware option low keeps a start request standing from reset on
    assign ctl.clk_en = CLK_EN_IN;
    assign ctl.lsi_tick = LSI_TICK_IN;
    assign ctl.freeze = DEBUG_HALT_IN && DEBUG_HALT_FREEZE_IN;
    assign ctl.permit = RESET_PERMIT_IN;
    assign ctl.start_req = start_cmd || !HW_START_OPTION_IN;
    assign ctl.reload_req = reload_cmd;
    assign ctl.div_sel = div_active_reg;
    assign ctl.restart_val = restart_active_reg;
    assign SYS_RESET_OUT = ctl.sys_reset;

    indwd_prescaler u_prescaler (
        .ctl(ctl.presc)
    );

    indwd_counter u_counter (
        .ctl(ctl.cnt)
    );

    // ****************************************
    // Checks
    // ****************************************
    a_unlock_opens: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (CLK_EN_IN && cmd_wr && cmd_word == `INDWD_CMD_UNLOCK) |=> unlock_reg)
        else $error("unlock command did not open protection");
    a_reload_locks: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (CLK_EN_IN && reload_cmd) |=> !unlock_reg)
        else $error("reload left protection open");
    a_div_locked: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (wr_fire && aw_sel_reg == `INDWD_OFF_DIV && (!unlock_reg || div_pend_reg)) |=>
        $stable(div_reg))
        else $error("protected divider changed");
    a_rst_locked: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (wr_fire && aw_sel_reg == `INDWD_OFF_RST && !unlock_reg) |=> $stable(restart_reg))
        else $error("protected restart value changed");
    a_pend_raise: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (CLK_EN_IN && restart_wr) |=> restart_pend_reg && restart_active_reg != 12'h000 ||
        restart_pend_reg)
        else $error("restart update did not raise pending");
    a_pend_drop: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (CLK_EN_IN && div_pend_reg && LSI_TICK_IN) |=>
        (!div_pend_reg && div_active_reg == div_reg))
        else $error("divider update did not complete on tick");
    a_junk_cmd: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (CLK_EN_IN && cmd_wr && cmd_word != `INDWD_CMD_UNLOCK) |=> !unlock_reg)
        else $error("stray command unlocked registers");
endmodule

/* File: test/independent_watchdog_test.sv */
// Self-checking bench for the independent watchdog top over AXI4-Lite.
// Assumes the design files compile first; the bench drives every port itself.
`timescale 1ns/10ps
`include "indwd_defs.svh"
module independent_watchdog_test;
    // ****************************************
    // Signals, clock and design
    // ****************************************
    logic clk = 1'b0, rst = 1'b1, tick = 1'b0, permit = 1'b1, halt = 1'b0, frz = 1'b0;
    logic hwopt = 1'b1;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, sys_rst;
    logic [1:0] bresp, rresp;
    int miscompares = 0, cmp_count = 0;
    // 10 MHz core clock
    always #50 clk = ~clk;
    // Clock enable and strobes are tied off
    indwd_top u_dut (.CORE_CLK_IN(clk), .RESET_IN(rst), .CLK_EN_IN(1'b1), .LSI_TICK_IN(tick),
        .HW_START_OPTION_IN(hwopt), .RESET_PERMIT_IN(permit), .DEBUG_HALT_IN(halt),
        .DEBUG_HALT_FREEZE_IN(frz), .SYS_RESET_OUT(sys_rst), .S_AXI_AWADDR_IN(awaddr),
        .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
        .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
        .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
        .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
        .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
        .S_AXI_RREADY_IN(rready));
    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // Handshakes are judged before the edge, released right after it
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        logic [1:0] r;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                chk("bresp", 32'h0, {30'h0, r});
                break;
            end
        end
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(negedge clk);
            ta = arvalid && arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0;
                chk("rdata", e, d);
                chk("rresp", {30'h0, er}, {30'h0, r});
                break;
            end
        end
    endtask
    // One-cycle oscillator ticks, one every other core cycle
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
    endtask
    task automatic rst_chk(input logic e);
        @(negedge clk);
        chk("sys_reset", {31'h0, e}, {31'h0, sys_rst});
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        rdc(`INDWD_OFF_CMD, 32'h0, 2'h0);
        rdc(`INDWD_OFF_DIV, 32'h0, 2'h0);
        rdc(`INDWD_OFF_RST, 32'h00000FFF, 2'h0);
        rdc(`INDWD_OFF_STS, 32'h0, 2'h0);
        rdc(4'h2, 32'h0, `INDWD_RESP_SLVERR);
        wr(`INDWD_OFF_RST, 32'h5);
        rdc(`INDWD_OFF_RST, 32'h00000FFF, 2'h0);
    endtask
    // Pending flags rise on write and fall at the next tick
    task automatic t_unlock();
        wr(`INDWD_OFF_CMD, `INDWD_CMD_UNLOCK);
        wr(`INDWD_OFF_RST, 32'h2);
        rdc(`INDWD_OFF_STS, 32'h2, 2'h0);
        wr(`INDWD_OFF_RST, 32'h7);
        ticks(1);
        rdc(`INDWD_OFF_STS, 32'h0, 2'h0);
        rdc(`INDWD_OFF_RST, 32'h2, 2'h0);
        wr(`INDWD_OFF_DIV, 32'h1);
        rdc(`INDWD_OFF_STS, 32'h1, 2'h0);
        wr(`INDWD_OFF_DIV, 32'h3);
        rdc(`INDWD_OFF_DIV, 32'h1, 2'h0);
        ticks(1);
        wr(`INDWD_OFF_DIV, 32'h0);
        ticks(1);
        rdc(`INDWD_OFF_STS, 32'h0, 2'h0);
        wr(`INDWD_OFF_CMD, 32'h1234);
        wr(`INDWD_OFF_RST, 32'h9);
        rdc(`INDWD_OFF_RST, 32'h2, 2'h0);
    endtask
    // Restart value 2 at divide-by-4 fires after eight ticks
    task automatic t_run();
        wr(`INDWD_OFF_CMD, `INDWD_CMD_START);
        wr(`INDWD_OFF_CMD, `INDWD_CMD_UNLOCK);
        wr(`INDWD_OFF_CMD, `INDWD_CMD_RELOAD);
        wr(`INDWD_OFF_RST, 32'h9);
        rdc(`INDWD_OFF_RST, 32'h2, 2'h0);
        @(posedge clk);
        permit <= 1'b0;
        ticks(12);
        rst_chk(1'b0);
        wr(`INDWD_OFF_CMD, `INDWD_CMD_RELOAD);
        @(posedge clk);
        permit <= 1'b1;
        halt <= 1'b1;
        frz <= 1'b1;
        ticks(12);
        rst_chk(1'b0);
        @(posedge clk);
        halt <= 1'b0;
        frz <= 1'b0;
        ticks(7);
        rst_chk(1'b0);
        ticks(1);
        repeat (3) @(posedge clk);
        rst_chk(1'b1);
    endtask
    // Mid-run reset with hardware start; halt without freeze keeps counting.
    // A start command while running must not reload full scale.
    task automatic t_hw();
        @(posedge clk);
        rst <= 1'b1;
        hwopt <= 1'b0;
        halt <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rst_chk(1'b0);
        wr(`INDWD_OFF_CMD, `INDWD_CMD_UNLOCK);
        wr(`INDWD_OFF_RST, 32'h1);
        wr(`INDWD_OFF_DIV, 32'h1);
        ticks(1);
        wr(`INDWD_OFF_CMD, `INDWD_CMD_RELOAD);
        wr(`INDWD_OFF_CMD, `INDWD_CMD_START);
        ticks(7);
        rst_chk(1'b0);
        ticks(1);
        repeat (3) @(posedge clk);
        rst_chk(1'b1);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence after a 16-cycle reset
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_unlock();
        t_run();
        t_hw();
        tally_and_finish();
    end
    // Hang guard, well beyond the few hundred cycles the tests need
    initial begin
        #500000;
        miscompares++;
        tally_and_finish();
    end
endmodule
